/* logic/tsc_main_control.sv */
// main control register of the tdm stream switch, with its decodes
// assumes asynchronous host pins and frame/clock pins; all synchronised here
//
// Functional notes
// - control register decoded at index zero
// - mode 111 both bands, 000 low only
// - mode field ignored while discriminator disabled
// - bit 10 enables frame boundary discrimination
// - bit 12 low: fixed three-quarter sampling
// - bit 12 high: programmable sample point
// - local bit 9 low: sixteen programmable streams
// - local bit 9 high: streams 0-7 at 32M
// - backplane bit 7 mirrors local fixed mode
// - narrow mode outputs 122 ns and 61 ns
// - wide mode 244 ns in, 244/122 out
// - bit 6 picks falling or rising edge
// - address bit 14 low selects registers
`timescale 1ns/1ns
`default_nettype none
module tsc_main_control (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [tsc_pkg::ADDR_W-1:0] upAddr,
  input wire logic [tsc_pkg::DATA_W-1:0] upDataIn,
  output logic [tsc_pkg::DATA_W-1:0] upDataOut,
  output logic upDataOeN,
  input wire logic upChipSelN,
  input wire logic upStrobeN,
  input wire logic upReadWriteN,
  output logic upAckN,
  input wire logic inputClock,
  input wire logic framePulseIn,
  output logic framePulseOutSlow,
  output logic framePulseOutFast,
  output logic frameBoundary,
  output logic discriminatorEnable,
  output logic discriminatorBothBands,
  output logic discriminatorLowBand,
  output logic discriminatorModeReserved,
  output logic samplePointMode,
  output logic sampleFixedThreeQuarter,
  output logic localFixed32mMode,
  output logic backplaneFixed32mMode,
  output logic [tsc_pkg::STREAMS-1:0] localStreamEnable,
  output logic [tsc_pkg::STREAMS-1:0] backplaneStreamEnable
);
  import tsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rstMetaN; // first stage, read only by the second
  logic rstN; // released reset used everywhere below
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaN <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMetaN <= 1'b1;
      rstN <= rstMetaN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops each; address and data are assumed
  // stable before the strobe falls, so the strobe's extra edge covers skew
  logic [ADDR_W-1:0] addrMeta, addrSync;
  logic [DATA_W-1:0] dataMeta, dataSync;
  logic [2:0] ctlMeta, ctlSync; // {select, strobe, read} active high
  logic [1:0] lnkMeta, lnkSync; // {input clock, frame pulse}
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      addrMeta <= '0;
      addrSync <= '0;
      dataMeta <= '0;
      dataSync <= '0;
      ctlMeta <= 3'h0;
      ctlSync <= 3'h0;
      lnkMeta <= 2'h0;
      lnkSync <= 2'h0;
    end else begin
      addrMeta <= upAddr;
      addrSync <= addrMeta;
      dataMeta <= upDataIn;
      dataSync <= dataMeta;
      ctlMeta <= {~upChipSelN, ~upStrobeN, upReadWriteN};
      ctlSync <= ctlMeta;
      lnkMeta <= {inputClock, framePulseIn};
      lnkSync <= lnkMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hitsReg(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
    hitsReg = (a[REG_SPACE_BIT] == 1'b0) && (a[13:0] == idx);
  endfunction

  wire accessReq = ctlSync[2] & ctlSync[1]; // select and strobe both active
  wire isRead = ctlSync[0];
  wire mainHit = hitsReg(addrSync, MAIN_CONTROL_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // bus state: one access per strobe, ack held until strobe releases
  tsc_bus_state_e state_reg, state_next;
  wire accessStart = (state_reg == BUS_IDLE) && accessReq;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BUS_IDLE: begin
        if (accessReq) begin
          state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        if (!accessReq) begin
          state_next = BUS_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // main control storage; bits 5:0 belong elsewhere and read zero.
  // bit 11 is kept as written; the host is expected to leave it zero
  logic [DATA_W-1:IMPL_LSB] ctrl_reg;
  wire ctrlWrite = accessStart && !isRead && mainHit;
  wire [DATA_W-1:0] ctrlView = {ctrl_reg, {IMPL_LSB{1'b0}}};
  // unmapped reads answer zero rather than float
  wire [DATA_W-1:0] readValue = mainHit ? ctrlView : '0;

  logic [DATA_W-1:0] rdData_reg;
  logic oeN_reg;
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_reg <= BUS_IDLE;
      ctrl_reg <= MAIN_CONTROL_RESET[DATA_W-1:IMPL_LSB];
      rdData_reg <= '0;
      oeN_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (ctrlWrite) begin
        ctrl_reg <= dataSync[DATA_W-1:IMPL_LSB];
      end
      if (accessStart && isRead) begin
        rdData_reg <= readValue;
        oeN_reg <= 1'b0;
      end else if (!accessReq) begin
        oeN_reg <= 1'b1;
      end
    end
  end

  assign upDataOut = rdData_reg;
  assign upDataOeN = oeN_reg;
  assign upAckN = (state_reg != BUS_ACK);

  ////////////////////////////////////////////////////////////////////////
  // field decodes
  wire [2:0] discMode = ctrl_reg[DISC_MODE_MSB:DISC_MODE_LSB];
  assign discriminatorEnable = ctrl_reg[DISC_EN_BIT];
  // mode only counts while enabled
  assign discriminatorBothBands = discriminatorEnable && (discMode == DISC_BOTH_BANDS);
  assign discriminatorLowBand = discriminatorEnable && (discMode == DISC_LOW_BAND);
  assign discriminatorModeReserved = discriminatorEnable && !discriminatorBothBands
    && !discriminatorLowBand;
  assign samplePointMode = ctrl_reg[SAMPLE_MODE_BIT];
  assign sampleFixedThreeQuarter = !ctrl_reg[SAMPLE_MODE_BIT];
  assign localFixed32mMode = ctrl_reg[LOCAL32_BIT];
  assign backplaneFixed32mMode = ctrl_reg[BP32_BIT];
  // streams 8-15 unused in fixed 32M mode
  assign localStreamEnable = localFixed32mMode ? LOW_EIGHT_STREAMS : ALL_STREAMS;
  assign backplaneStreamEnable = backplaneFixed32mMode ? LOW_EIGHT_STREAMS : ALL_STREAMS;

  ////////////////////////////////////////////////////////////////////////
  // frame boundary: chosen input clock edge while frame pulse is high,
  // once per pulse so a wide pulse spanning two edges counts once
  logic clkPrev_reg;
  logic taken_reg;
  wire risingEdge = lnkSync[1] && !clkPrev_reg;
  wire fallingEdge = !lnkSync[1] && clkPrev_reg;
  wire chosenEdge = ctrl_reg[EDGE_SEL_BIT] ? risingEdge : fallingEdge;
  wire boundaryHit = chosenEdge && lnkSync[0] && !taken_reg;
  logic boundary_reg;
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      clkPrev_reg <= 1'b0;
      taken_reg <= 1'b0;
      boundary_reg <= 1'b0;
    end else begin
      clkPrev_reg <= lnkSync[1];
      taken_reg <= lnkSync[0] && (taken_reg || boundaryHit);
      boundary_reg <= boundaryHit;
    end
  end
  assign frameBoundary = boundary_reg;

  ////////////////////////////////////////////////////////////////////////
  // frame pulse outputs, width set by the pulse width select
  wire wideSel = ctrl_reg[FPW_BIT];
  wire [7:0] slowWidth = wideSel ? FP_SLOW_WIDE_CYC : FP_SLOW_NARROW_CYC;
  wire [7:0] fastWidth = wideSel ? FP_FAST_WIDE_CYC : FP_FAST_NARROW_CYC;

  tsc_pulse_gen slowGen (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .start(boundary_reg),
    .width(slowWidth),
    .pulse(framePulseOutSlow)
  );
  tsc_pulse_gen fastGen (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .start(boundary_reg),
    .width(fastWidth),
    .pulse(framePulseOutFast)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] fastLen_reg; // length of the current fast pulse
  logic [7:0] fastExp_reg; // width latched at pulse start
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      fastLen_reg <= 8'h00;
      fastExp_reg <= 8'h00;
    end else begin
      fastLen_reg <= framePulseOutFast ? fastLen_reg + 8'h01 : 8'h00;
      if (boundary_reg) begin
        fastExp_reg <= fastWidth;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  property p_write_takes;
    ctrlWrite |=> (ctrl_reg == $past(dataSync[DATA_W-1:IMPL_LSB]));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("write not stored");

  property p_outer_space;
    (accessStart && !isRead && addrSync[REG_SPACE_BIT]) |=> $stable(ctrl_reg);
  endproperty
  a_outer_space: assert property (p_outer_space) else $error("memory write hit reg");

  property p_read_back;
    (accessStart && isRead && mainHit) |=> (upDataOut == ctrlView) && !upDataOeN && !upAckN;
  endproperty
  a_read_back: assert property (p_read_back) else $error("read back wrong");

  property p_disc_off;
    !ctrl_reg[DISC_EN_BIT] |-> !discriminatorBothBands && !discriminatorLowBand
      && !discriminatorModeReserved;
  endproperty
  a_disc_off: assert property (p_disc_off) else $error("mode used while disabled");

  property p_disc_both;
    (ctrl_reg[DISC_EN_BIT] && ctrl_reg[DISC_MODE_MSB:DISC_MODE_LSB] == 3'h7)
      |-> discriminatorBothBands && !discriminatorLowBand;
  endproperty
  a_disc_both: assert property (p_disc_both) else $error("both-band decode wrong");

  property p_sample;
    sampleFixedThreeQuarter == !ctrl_reg[12];
  endproperty
  a_sample: assert property (p_sample) else $error("sample mode decode wrong");

  property p_local_streams;
    ctrl_reg[9] ? (localStreamEnable == 16'h00FF) : (localStreamEnable == 16'hFFFF);
  endproperty
  a_local_streams: assert property (p_local_streams) else $error("local streams wrong");

  property p_bp_streams;
    ctrl_reg[7] ? (backplaneStreamEnable == 16'h00FF) : (backplaneStreamEnable == 16'hFFFF);
  endproperty
  a_bp_streams: assert property (p_bp_streams) else $error("backplane streams wrong");

  property p_fast_width;
    $fell(framePulseOutFast) && !$past(boundary_reg) |-> ($past(fastLen_reg) + 8'h01 ==
      fastExp_reg);
  endproperty
  a_fast_width: assert property (p_fast_width) else $error("fast pulse width wrong");

  property p_slow_start;
    (boundary_reg && ctrl_reg[8]) |=> framePulseOutSlow [*8];
  endproperty
  a_slow_start: assert property (p_slow_start) else $error("slow pulse too short");

  property p_edge;
    frameBoundary |-> ($past(ctrl_reg[6]) ? $past(risingEdge) : $past(fallingEdge));
  endproperty
  a_edge: assert property (p_edge) else $error("boundary on wrong edge");

endmodule
`default_nettype wire

/* logic/tsc_pkg.sv */
// constants, field layout and states for the switch main control register
// assumes a single 250 MHz system clock; pins arrive asynchronously
`default_nettype none
package tsc_pkg;

  // bus widths of the parallel microprocessor port
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;

  // internal register space select and register index
  localparam int REG_SPACE_BIT = 14;
  localparam logic [13:0] MAIN_CONTROL_ADDR = 14'h0000;

  // main_control field positions
  localparam int DISC_MODE_MSB = 15;
  localparam int DISC_MODE_LSB = 13;
  localparam int SAMPLE_MODE_BIT = 12;
  localparam int RESERVED_BIT = 11;
  localparam int DISC_EN_BIT = 10;
  localparam int LOCAL32_BIT = 9;
  localparam int FPW_BIT = 8;
  localparam int BP32_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int IMPL_LSB = 6;

  // value after reset and decode codes
  localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0000;
  localparam logic [2:0] DISC_BOTH_BANDS = 3'h7;
  localparam logic [2:0] DISC_LOW_BAND = 3'h0;

  // stream enable patterns
  localparam int STREAMS = 16;
  localparam logic [15:0] ALL_STREAMS = 16'hFFFF;
  localparam logic [15:0] LOW_EIGHT_STREAMS = 16'h00FF;

  // frame pulse widths in ns and in clock cycles (rounded up)
  localparam int CLK_PERIOD_NS = 4;
  localparam int FP_SLOW_NARROW_NS = 122;
  localparam int FP_FAST_NARROW_NS = 61;
  localparam int FP_SLOW_WIDE_NS = 244;
  localparam int FP_FAST_WIDE_NS = 122;
  localparam logic [7:0] FP_SLOW_NARROW_CYC =
    8'((FP_SLOW_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FP_FAST_NARROW_CYC =
    8'((FP_FAST_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FP_SLOW_WIDE_CYC =
    8'((FP_SLOW_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FP_FAST_WIDE_CYC =
    8'((FP_FAST_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // bus access states
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} tsc_bus_state_e;

endpackage
`default_nettype wire

/* logic/tsc_pulse_gen.sv */
// one-shot pulse generator for the frame pulse outputs
// assumes start is a one-cycle pulse on clk_sys and width is stable
`timescale 1ns/1ns
`default_nettype none
module tsc_pulse_gen (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic start,
  input wire logic [7:0] width,
  output logic pulse
);
  import tsc_pkg::*;

  logic [7:0] count_reg; // cycles left in the pulse
  logic [7:0] count_next;
  logic pulse_reg;
  logic pulse_next;

  ////////////////////////////////////////////////////////////////////////
  // next values: a new start restarts the pulse even mid-pulse
  assign count_next = start ? width : ((count_reg != 8'h00) ? count_reg - 8'h01 : 8'h00);
  assign pulse_next = start ? (width != 8'h00) : (count_reg > 8'h01);
  assign pulse = pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // counter and registered pulse
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      count_reg <= 8'h00;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

endmodule
`default_nettype wire

/* sim/tsc_host_model.sv */
// host processor on the parallel register port, one access at a time
// assumes the bench calls access from one process only
`timescale 1ns/1ns
`default_nettype none
module tsc_host_model (
  input wire logic clk_sys,
  output var logic [14:0] upAddr,
  output var logic [15:0] upDataIn,
  output var logic upChipSelN,
  output var logic upStrobeN,
  output var logic upReadWriteN,
  input wire logic [15:0] upDataOut,
  input wire logic upDataOeN,
  input wire logic upAckN
);
  // bus idle from time zero
  initial begin
    upAddr = 15'h0000;
    upDataIn = 16'h0000;
    upChipSelN = 1'b1;
    upStrobeN = 1'b1;
    upReadWriteN = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // strobed access; ok drops if an answer or release never shows
  task automatic access(input logic rd, input logic [14:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
    int n;
    @(negedge clk_sys);
    upAddr = a;
    upReadWriteN = rd;
    // data pins wander on reads so stale data cannot pass
    upDataIn = rd ? ~upDataIn : (d & 16'hF7FF);
    // two cycles of setup before the strobe
    repeat (2) @(negedge clk_sys);
    upChipSelN = 1'b0;
    upStrobeN = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (upAckN !== 1'b0 && n < 20);
    // data driver on only while a read is answered
    ok = (upAckN === 1'b0) && (rd ? (upDataOeN === 1'b0) : (upDataOeN === 1'b1));
    q = upDataOut;
    @(negedge clk_sys);
    upChipSelN = 1'b1;
    upStrobeN = 1'b1;
    // next access only once the release is acknowledged
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (upAckN !== 1'b1 && n < 20);
    ok = ok && (upAckN === 1'b1) && (upDataOeN === 1'b1);
  endtask
endmodule
`default_nettype wire

/* sim/tsc_main_control_tb.sv */
// self-checking bench for the switch main control register
// assumes the host model file is compiled before this one
`timescale 1ns/1ns
`default_nettype none
module tsc_main_control_tb;
  import tsc_pkg::*;
  // one table row: value written, decode flags expected
  typedef struct packed {logic [15:0] wr; logic [7:0] flags;} tsc_row_s;
  logic clk_sys, reset_n, inputClock, framePulseIn;
  wire logic [14:0] upAddr;
  wire logic [15:0] upDataIn, upDataOut, localStreamEnable, backplaneStreamEnable;
  wire logic upChipSelN, upStrobeN, upReadWriteN, upAckN, upDataOeN;
  wire logic frameBoundary, fpSlow, fpFast, dEn, dBoth, dLow, dResv, spm, fix3q, l32, b32;
  wire logic [7:0] flags;
  logic [15:0] q;
  int n_mismatch, compares;
  // flags: enable, both, low, reserved, sample mode, fixed 3/4, local32, backplane32
  tsc_row_s rows [10] = '{'{16'hE400, 8'hC4}, '{16'h0400, 8'hA4}, '{16'h6400, 8'h94},
    '{16'h3400, 8'h98}, '{16'hA400, 8'h94}, '{16'hE000, 8'h04}, '{16'h1000, 8'h08},
    '{16'h0200, 8'h06}, '{16'h0080, 8'h05}, '{16'h13FF, 8'h0B}};
  assign flags = {dEn, dBoth, dLow, dResv, spm, fix3q, l32, b32};
  //////////////////////////////////////////////////////////////////////
  // design and host
  tsc_main_control i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .upAddr(upAddr),
    .upDataIn(upDataIn), .upDataOut(upDataOut), .upDataOeN(upDataOeN), .upChipSelN(upChipSelN),
    .upStrobeN(upStrobeN), .upReadWriteN(upReadWriteN), .upAckN(upAckN),
    .inputClock(inputClock), .framePulseIn(framePulseIn), .framePulseOutSlow(fpSlow),
    .framePulseOutFast(fpFast), .frameBoundary(frameBoundary), .discriminatorEnable(dEn),
    .discriminatorBothBands(dBoth), .discriminatorLowBand(dLow),
    .discriminatorModeReserved(dResv), .samplePointMode(spm),
    .sampleFixedThreeQuarter(fix3q), .localFixed32mMode(l32), .backplaneFixed32mMode(b32),
    .localStreamEnable(localStreamEnable), .backplaneStreamEnable(backplaneStreamEnable));
  tsc_host_model i_host (.clk_sys(clk_sys), .upAddr(upAddr), .upDataIn(upDataIn),
    .upChipSelN(upChipSelN), .upStrobeN(upStrobeN), .upReadWriteN(upReadWriteN),
    .upDataOut(upDataOut), .upDataOeN(upDataOeN), .upAckN(upAckN));
  //////////////////////////////////////////////////////////////////////
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // input clock a little slow so frame pulses keep margin to the edges
  initial begin
    inputClock = 1'b0;
    forever begin
      repeat (17) @(negedge clk_sys);
      inputClock = ~inputClock;
    end
  end
  // watchdog well beyond the expected run of under 1500 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    conclude;
  end
  //////////////////////////////////////////////////////////////////////
  // compare helpers
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chkCount(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask
  // register accesses; the handshake itself is checked each time
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    i_host.access(1'b0, a, d, r, ok);
    chkCount(int'(ok), 1);
  endtask
  task automatic rd(input logic [14:0] a, output logic [15:0] r);
    logic ok;
    i_host.access(1'b1, a, 16'h0000, r, ok);
    chkCount(int'(ok), 1);
  endtask
  // one input frame pulse started just after a rising input clock edge
  task automatic frame(input logic [15:0] ctrl, input int wCyc, input int nB, input int nS,
      input int nF);
    int b, s, f;
    b = 0;
    s = 0;
    f = 0;
    wr(15'h0000, ctrl);
    @(posedge inputClock);
    @(negedge clk_sys);
    fork
      begin
        framePulseIn = 1'b1;
        repeat (wCyc) @(negedge clk_sys);
        framePulseIn = 1'b0;
      end
      repeat (200) begin
        @(posedge clk_sys);
        b += int'(frameBoundary === 1'b1);
        s += int'(fpSlow === 1'b1);
        f += int'(fpFast === 1'b1);
      end
    join
    chkCount(b, nB);
    chkCount(s, nS);
    chkCount(f, nF);
  endtask
  // verdict and end of run
  task automatic conclude;
    $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence: reset value, then table, then reset, decode and frame cases
  initial begin
    reset_n = 1'b0;
    framePulseIn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    rd(15'h0000, q);
    chkWord(q, MAIN_CONTROL_RESET);
    foreach (rows[i]) begin
      wr(15'h0000, rows[i].wr);
      rd(15'h0000, q);
      chkWord(q, rows[i].wr & 16'hFFC0);
      chkWord({8'h00, flags}, {8'h00, rows[i].flags});
      chkWord(localStreamEnable, rows[i].flags[1] ? LOW_EIGHT_STREAMS : ALL_STREAMS);
      chkWord(backplaneStreamEnable, rows[i].flags[0] ? LOW_EIGHT_STREAMS : ALL_STREAMS);
    end
    // second reset in mid-run clears a loaded register
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chkWord({8'h00, flags}, 16'h0004);
    rd(15'h0000, q);
    chkWord(q, 16'h0000);
    // writes outside the register or the register space leave it alone
    wr(15'h0000, 16'h0400);
    wr(15'h4000, 16'hFFFF);
    wr(15'h0001, 16'hFFFF);
    rd(15'h0000, q);
    chkWord(q, 16'h0400);
    rd(15'h4000, q);
    chkWord(q, 16'h0000);
    // frame width and edge choice
    frame(16'h0000, 31, 1, FP_SLOW_NARROW_CYC, FP_FAST_NARROW_CYC);
    frame(16'h0040, 31, 0, 0, 0);
    frame(16'h0100, 61, 1, FP_SLOW_WIDE_CYC, FP_FAST_WIDE_CYC);
    frame(16'h0140, 61, 1, FP_SLOW_WIDE_CYC, FP_FAST_WIDE_CYC);
    conclude;
  end
endmodule
`default_nettype wire
